//--- rtl/board_time_pkg.sv
package board_time_pkg;

  // time word layout
  localparam int unsigned SEC_BITS      = 32;
  localparam int unsigned FRAC_FULL     = 32;
  localparam int unsigned FRAC_BITS     = 20;
  localparam int unsigned FRAC_PAD      = FRAC_FULL - FRAC_BITS;
  localparam int unsigned STATUS_BITS   = FRAC_PAD;
  localparam int unsigned PERIOD_BITS   = 16;

  // clock rate and tick phase accumulator
  localparam longint unsigned CLOCK_HZ  = 64'd100_000_000;
  localparam int unsigned     ACC_BITS  = 32;
  localparam longint unsigned TICK_INC_L =
    (64'd1 << (ACC_BITS + FRAC_BITS)) / CLOCK_HZ;
  localparam logic [ACC_BITS-1:0] TICK_INC = TICK_INC_L[ACC_BITS-1:0];

  // reset values and other fixed constants
  localparam logic [SEC_BITS-1:0]    SEC_RESET    = 32'h0000_0000;
  localparam logic [FRAC_BITS-1:0]   FRAC_RESET   = 20'h0_0000;
  localparam logic [FRAC_BITS-1:0]   FRAC_MAX     = 20'hF_FFFF;
  localparam logic [PERIOD_BITS-1:0] PERIOD_RESET = 16'h0000;
  localparam logic [PERIOD_BITS-1:0] AUTO_PERIOD  = 16'h0400;
  localparam logic [FRAC_PAD-1:0]    FRAC_ZERO    = 12'h000;

  // adjustment modes
  typedef enum logic [1:0] {
    ADJ_OFF  = 2'b00,
    ADJ_ADD  = 2'b01,
    ADJ_HOLD = 2'b10
  } adj_mode_t;

  // current time, fractional part as implemented
  typedef struct packed {
    logic [SEC_BITS-1:0]  sec;
    logic [FRAC_BITS-1:0] frac;
  } time_t;

  // host trim setting
  typedef struct packed {
    adj_mode_t              mode;
    logic [PERIOD_BITS-1:0] period;
  } adj_cfg_t;

  // two stream words carrying a timestamp
  typedef struct packed {
    logic [SEC_BITS-1:0]  word0;
    logic [FRAC_FULL-1:0] word1;
  } stamp_t;

endpackage

//--- rtl/board_timestamp_clock.sv
// Overview of operation
// RULE_01 - time is 64 bits; top 32 bits are low 32 bits of epoch seconds
// RULE_02 - low 32 bits are a binary fraction of one second, about 233 ps per count
// RULE_03 - only the top twenty fraction bits are kept, about 954 ns resolution
// RULE_04 - seconds advance by one when the fraction wraps; seconds wrap modulo 2^32
// RULE_05 - adjustment counter overflow adds an extra step or holds the fraction lsb
// RULE_06 - with adjustment, successive lsb readings may repeat or jump by two
// RULE_07 - time loads from an external source or from host software directly
// RULE_08 - locked to an external time code, rate trim runs by itself
// RULE_09 - host trims gradually so time converges and never runs backwards
// RULE_10 - counting starts at reset release with no start command
// RULE_11 - one counter serves every channel; all see the same value
// RULE_12 - host can read back the whole 64-bit time value
// RULE_13 - stream stamp: seconds word, then fraction sharing a word with status
`timescale 1ns/1ps
module board_timestamp_clock (
  // clock and reset
  input  wire logic                                     clock,
  input  wire logic                                     rst_n,
  // host load and trim
  input  wire logic                                     set_valid,
  input  wire board_time_pkg::time_t                    set_time,
  input  wire board_time_pkg::adj_cfg_t                 adj_cfg,
  // host read back
  input  wire logic                                     read_req,
  output logic                                          read_valid,
  output logic [63:0]                                   read_time,
  // external time source
  input  wire logic                                     ext_sync_en,
  input  wire logic                                     ext_load_valid,
  input  wire board_time_pkg::time_t                    ext_load_time,
  input  wire logic                                     pps_pin,
  // data stream stamp
  input  wire logic                                     stamp_req,
  input  wire logic [board_time_pkg::STATUS_BITS-1:0]   stamp_status,
  output logic                                          stamp_valid,
  output board_time_pkg::stamp_t                        stamp,
  // live time and trim state
  output logic [63:0]                                   time_now,
  output logic                                          auto_add,
  output logic                                          auto_hold
);
  import board_time_pkg::*;

  logic                   tick;
  logic                   pps_sync;
  logic                   pps_last_q;
  logic                   pps_rise;
  time_t                  time_q;
  time_t                  time_d;
  logic [PERIOD_BITS-1:0] adj_cnt_q;
  logic [PERIOD_BITS-1:0] eff_period;
  adj_mode_t              eff_mode;
  logic                   adj_event;
  logic [1:0]             step;
  logic [FRAC_BITS:0]     frac_sum;
  logic                   auto_add_q;
  logic                   auto_hold_q;
  logic                   read_valid_q;
  logic [63:0]            read_time_q;
  logic                   stamp_valid_q;
  stamp_t                 stamp_q;

  // fractional step timebase
  frac_tick_gen #(
    .ACC_W (ACC_BITS),
    .INC   (TICK_INC)
  ) u_tick (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (tick)
  );

  // pulse-per-second pin comes from outside the clock domain
  sync_two_ff u_pps_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (pps_pin),
    .sync_out (pps_sync)
  );

  // edge detect on the synchronised pps only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pps_last_q <= 1'b0;
    end else begin
      pps_last_q <= pps_sync;
    end
  end

  assign pps_rise = pps_sync && !pps_last_q;

  // trim source: external lock overrides host setting
  always_comb begin
    eff_mode   = adj_cfg.mode;
    eff_period = adj_cfg.period;
    if (ext_sync_en) begin // RULE_08
      eff_period = AUTO_PERIOD;
      if (auto_add_q) begin
        eff_mode = ADJ_ADD;
      end else if (auto_hold_q) begin
        eff_mode = ADJ_HOLD;
      end else begin
        eff_mode = ADJ_OFF;
      end
    end
  end

  // automatic trim direction from fraction seen at each pps edge
  // fraction in the upper half means the board runs slow
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      auto_add_q  <= 1'b0;
      auto_hold_q <= 1'b0;
    end else if (!ext_sync_en) begin
      auto_add_q  <= 1'b0;
      auto_hold_q <= 1'b0;
    end else if (pps_rise) begin // RULE_08
      auto_add_q  <= time_q.frac[FRAC_BITS-1];
      auto_hold_q <= !time_q.frac[FRAC_BITS-1] && (time_q.frac != FRAC_RESET);
    end
  end

  // adjustment counter counts fraction steps; period zero disables its events
  assign adj_event = tick && (eff_mode != ADJ_OFF) && (eff_period != PERIOD_RESET)
                     && (adj_cnt_q == eff_period - 16'h0001); // RULE_05

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      adj_cnt_q <= PERIOD_RESET;
    end else if (eff_mode == ADJ_OFF || adj_event) begin
      adj_cnt_q <= PERIOD_RESET;
    end else if (tick) begin
      adj_cnt_q <= adj_cnt_q + 16'h0001; // RULE_05
    end
  end

  // step size: one normally, two on add, zero on hold
  always_comb begin
    step = 2'd1;
    if (adj_event) begin
      unique case (eff_mode)
        ADJ_ADD:  step = 2'd2; // RULE_06
        ADJ_HOLD: step = 2'd0; // RULE_06
        default:  step = 2'd1;
      endcase
    end
  end

  assign frac_sum = {1'b0, time_q.frac} + {{(FRAC_BITS-1){1'b0}}, step};

  // next time: host load beats external load beats counting
  always_comb begin
    time_d = time_q;
    if (set_valid) begin
      time_d = set_time; // RULE_07
    end else if (ext_load_valid) begin
      time_d = ext_load_time; // RULE_07
    end else if (tick) begin
      time_d.frac = frac_sum[FRAC_BITS-1:0]; // RULE_03
      if (frac_sum[FRAC_BITS]) begin
        time_d.sec = time_q.sec + 32'h0000_0001; // RULE_04
      end
    end
  end

  // the one time counter; runs from reset release with no enable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      time_q <= '{sec: SEC_RESET, frac: FRAC_RESET}; // RULE_10
    end else begin
      time_q <= time_d; // RULE_11
    end
  end

  // live view: low fraction bits beyond the kept twenty read zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      time_now <= 64'h0000_0000_0000_0000;
    end else begin
      time_now <= {time_d.sec, time_d.frac, FRAC_ZERO}; // RULE_01 RULE_02
    end
  end

  // host read back of the full word, one cycle after the request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      read_valid_q <= 1'b0;
      read_time_q  <= 64'h0000_0000_0000_0000;
    end else begin
      read_valid_q <= read_req;
      if (read_req) begin
        read_time_q <= {time_q.sec, time_q.frac, FRAC_ZERO}; // RULE_12
      end
    end
  end

  // stream stamp: fraction high, caller's status in the low bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stamp_valid_q <= 1'b0;
      stamp_q       <= '0;
    end else begin
      stamp_valid_q <= stamp_req;
      if (stamp_req) begin
        stamp_q.word0 <= time_q.sec; // RULE_13
        stamp_q.word1 <= {time_q.frac, stamp_status}; // RULE_13
      end
    end
  end

  assign read_valid  = read_valid_q;
  assign read_time   = read_time_q;
  assign stamp_valid = stamp_valid_q;
  assign stamp       = stamp_q;
  assign auto_add    = auto_add_q;
  assign auto_hold   = auto_hold_q;

  // plain step: fraction advances by exactly one
  a_frac_plain_step: assert property (@(posedge clock) disable iff (!rst_n) // RULE_02
    (tick && !adj_event && !set_valid && !ext_load_valid)
    |=> time_q.frac == $past(time_q.frac) + 20'h0_0001)
    else $error("fraction did not advance by one");

  // add event skips one count
  a_frac_add_two: assert property (@(posedge clock) disable iff (!rst_n) // RULE_06
    (adj_event && eff_mode == ADJ_ADD && !set_valid && !ext_load_valid)
    |=> time_q.frac == $past(time_q.frac) + 20'h0_0002)
    else $error("add adjustment did not jump by two");

  // hold event repeats the value
  a_frac_hold_same: assert property (@(posedge clock) disable iff (!rst_n) // RULE_05
    (adj_event && eff_mode == ADJ_HOLD && !set_valid && !ext_load_valid)
    |=> $stable(time_q))
    else $error("hold adjustment changed the time");

  // seconds carry exactly on fraction wrap
  a_sec_carry: assert property (@(posedge clock) disable iff (!rst_n) // RULE_04
    (tick && time_q.frac == FRAC_MAX && step == 2'd1 && !set_valid && !ext_load_valid)
    |=> time_q.sec == $past(time_q.sec) + 32'h0000_0001 && time_q.frac == FRAC_RESET)
    else $error("seconds did not carry on wrap");

  // without tick or load nothing moves
  a_time_idle: assert property (@(posedge clock) disable iff (!rst_n) // RULE_11
    (!tick && !set_valid && !ext_load_valid) |=> $stable(time_q))
    else $error("time moved without a step");

  // host load takes effect next cycle
  a_host_load: assert property (@(posedge clock) disable iff (!rst_n) // RULE_07
    set_valid |=> time_q == $past(set_time))
    else $error("host load not applied");

  // read answer is the time at the request
  a_read_answer: assert property (@(posedge clock) disable iff (!rst_n) // RULE_12
    read_req |=> read_valid && read_time == {$past(time_q), FRAC_ZERO})
    else $error("read back wrong");

  // stamp words carry seconds, fraction and status
  a_stamp_format: assert property (@(posedge clock) disable iff (!rst_n) // RULE_13
    stamp_req |=> stamp_valid && stamp.word0 == $past(time_q.sec)
      && stamp.word1 == {$past(time_q.frac), $past(stamp_status)})
    else $error("stamp format wrong");

  // steps are far apart at this clock rate
  a_tick_spacing: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
    tick |=> !tick [*8])
    else $error("fraction steps too close");

  // external lock picks trim direction from the pps fraction
  a_auto_dir: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
    (ext_sync_en && pps_rise && time_q.frac[FRAC_BITS-1]) ##1 ext_sync_en
    |-> auto_add && !auto_hold)
    else $error("automatic trim direction wrong");

  // hold direction when the pps finds the fraction early in the second
  a_auto_hold_dir: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
    (ext_sync_en && pps_rise && !time_q.frac[FRAC_BITS-1] && time_q.frac != FRAC_RESET)
    ##1 ext_sync_en |-> auto_hold && !auto_add)
    else $error("automatic hold direction wrong");

  // leaving lock drops any automatic trim at the next edge
  a_auto_clear: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
    !ext_sync_en |=> !auto_add && !auto_hold)
    else $error("automatic trim kept outside lock");

  // external load applies whenever the host is not loading
  a_ext_load: assert property (@(posedge clock) disable iff (!rst_n) // RULE_07
    (ext_load_valid && !set_valid) |=> time_q == $past(ext_load_time))
    else $error("external load not applied");

  // counting alone never runs time backwards; only the seconds wrap may
  a_time_forward: assert property (@(posedge clock) disable iff (!rst_n) // RULE_06
    (!set_valid && !ext_load_valid && time_q.sec != 32'hFFFF_FFFF)
    |=> {time_q.sec, time_q.frac} >= $past({time_q.sec, time_q.frac}))
    else $error("time ran backwards");

  // answers follow each request cycle one cycle later and never come without one
  a_read_idle: assert property (@(posedge clock) disable iff (!rst_n) // RULE_12
    !read_req |=> !read_valid)
    else $error("read answer without request");

  a_stamp_idle: assert property (@(posedge clock) disable iff (!rst_n) // RULE_13
    !stamp_req |=> !stamp_valid)
    else $error("stamp without request");

  // live view mirrors the counter with the unkept bits at zero
  a_live_view: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
    time_now == {time_q, FRAC_ZERO})
    else $error("live time differs from counter");

endmodule

//--- rtl/frac_tick_gen.sv
`timescale 1ns/1ps
module frac_tick_gen #(
  parameter int unsigned         ACC_W = 32,
  parameter logic [ACC_W-1:0]    INC   = 32'h0000_0001
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // one pulse per fractional step
  output logic      tick
);
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W:0]   sum;

  assign sum = {1'b0, acc_q} + {1'b0, INC};

  // phase accumulator: carry out marks a step, so jitter is one clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      tick  <= 1'b0;
    end else begin
      acc_q <= sum[ACC_W-1:0];
      tick  <= sum[ACC_W];
    end
  end
endmodule

//--- rtl/sync_two_ff.sv
`timescale 1ns/1ps
module sync_two_ff (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // asynchronous level in, synchronised level out
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import board_time_pkg::*;

  logic                   clock = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   set_valid, read_req, read_valid, ext_sync_en, ext_load_valid;
  logic                   pps_pin, stamp_req, stamp_valid, auto_add, auto_hold;
  time_t                  set_time, ext_load_time;
  adj_cfg_t               adj_cfg;
  logic [63:0]            read_time, time_now;
  logic [STATUS_BITS-1:0] stamp_status;
  stamp_t                 stamp;
  int                     bad_count   = 0;
  int                     comparisons = 0;

  board_timestamp_clock i_dut (
    .clock(clock), .rst_n(rst_n), .set_valid(set_valid), .set_time(set_time),
    .adj_cfg(adj_cfg), .read_req(read_req), .read_valid(read_valid), .read_time(read_time),
    .ext_sync_en(ext_sync_en), .ext_load_valid(ext_load_valid),
    .ext_load_time(ext_load_time), .pps_pin(pps_pin), .stamp_req(stamp_req),
    .stamp_status(stamp_status), .stamp_valid(stamp_valid), .stamp(stamp),
    .time_now(time_now), .auto_add(auto_add), .auto_hold(auto_hold));

  // 100 MHz
  always #5 clock = ~clock;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // set_valid stays high so time is pinned until release_set
  task automatic load(input logic [31:0] s, input logic [19:0] f);
    @(posedge clock);
    set_valid <= 1'b1;
    set_time  <= {s, f};
    @(negedge clock);
  endtask

  task automatic release_set();
    @(posedge clock);
    set_valid <= 1'b0;
  endtask

  // bounded wait for the next fraction step
  task automatic wait_tick();
    logic [63:0] was;
    // sample off the edge so a load landing now is not taken for a step
    @(negedge clock);
    was = time_now;
    for (int i = 0; i < 200 && time_now === was; i++) @(negedge clock);
  endtask

  task automatic t_reset();
    repeat (5) @(posedge clock);
    check(time_now, 64'h0);
    rst_n <= 1'b1;
    wait_tick();
    check(time_now, {32'h0, 20'h0_0001, 12'h000});
  endtask

  // read and stamp in the same cycle see one counter
  task automatic t_read_stamp();
    load(32'h1234_5678, 20'hA_BCDE);
    @(posedge clock);
    read_req     <= 1'b1;
    stamp_req    <= 1'b1;
    stamp_status <= 12'hA5C;
    @(posedge clock);
    read_req  <= 1'b0;
    stamp_req <= 1'b0;
    @(negedge clock);
    check(read_valid, 1'b1);
    check(read_time, 64'h1234_5678_ABCD_E000);
    check(stamp_valid, 1'b1);
    check(stamp, 64'h1234_5678_ABCD_EA5C);
    check(read_time[63:12], {stamp.word0, stamp.word1[31:12]});
    @(negedge clock);
    check(read_valid, 1'b0);
    release_set();
  endtask

  task automatic t_carry();
    load(32'hFFFF_FFFF, 20'hF_FFFF);
    release_set();
    wait_tick();
    check(time_now, 64'h0);
  endtask

  // host load beats the external loader
  task automatic t_ext_load();
    load(32'h0000_0011, 20'h0_0022);
    @(posedge clock);
    ext_load_valid <= 1'b1;
    ext_load_time  <= {32'h0000_0033, 20'h0_0044};
    // both strobes are sampled at this edge
    @(posedge clock);
    set_valid <= 1'b0;
    @(negedge clock);
    check(time_now, {32'h11, 20'h0_0022, 12'h000});
    @(posedge clock);
    ext_load_valid <= 1'b0;
    @(negedge clock);
    check(time_now, {32'h33, 20'h0_0044, 12'h000});
  endtask

  // trim every tick: add steps by two, hold freezes
  task automatic t_trim();
    @(posedge clock);
    adj_cfg <= {ADJ_ADD, 16'h0001};
    load(32'h5, 20'h0_0000);
    release_set();
    wait_tick();
    check(time_now, {32'h5, 20'h0_0002, 12'h000});
    @(posedge clock);
    adj_cfg <= {ADJ_HOLD, 16'h0001};
    load(32'h5, 20'h0_0007);
    release_set();
    repeat (300) @(negedge clock);
    check(time_now, {32'h5, 20'h0_0007, 12'h000});
    @(posedge clock);
    adj_cfg <= {ADJ_OFF, 16'h0000};
  endtask

  task automatic pps_check(input logic [19:0] f, input logic a, input logic h);
    load(32'h100, f);
    @(posedge clock);
    pps_pin <= 1'b1;
    repeat (2) @(posedge clock);
    pps_pin <= 1'b0;
    repeat (8) @(negedge clock);
    check(auto_add, a);
    check(auto_hold, h);
  endtask

  // pps phase picks the automatic trim direction
  task automatic t_ext_mode();
    @(posedge clock);
    ext_sync_en <= 1'b1;
    pps_check(20'h8_0000, 1'b1, 1'b0);
    pps_check(20'h0_0010, 1'b0, 1'b1);
    pps_check(20'h8_0000, 1'b1, 1'b0);
    release_set();
    ext_sync_en <= 1'b0;
    repeat (4) @(negedge clock);
    check({auto_add, auto_hold}, 2'b00);
  endtask

  initial begin
    set_valid      = 1'b0;
    set_time       = '0;
    adj_cfg        = '0;
    read_req       = 1'b0;
    ext_sync_en    = 1'b0;
    ext_load_valid = 1'b0;
    ext_load_time  = '0;
    pps_pin        = 1'b0;
    stamp_req      = 1'b0;
    stamp_status   = 12'h000;
    t_reset();
    t_read_stamp();
    t_carry();
    t_ext_load();
    t_trim();
    t_ext_mode();
    finish_test();
  end

  // whole run needs under a thousand cycles
  initial begin
    #200_000;
    bad_count++;
    finish_test();
  end
endmodule
